// [include/lane_link_pkg.sv]
// shared constants, types and helpers for the lane link status block
package lane_link_pkg;
   // ********
   // sizes
   // ********
   localparam int LANES = 12;
   localparam int CAL_ENTRIES = 256;
   localparam int CAL_GROUP = 16;
   localparam int CAL_GROUPS = CAL_ENTRIES / CAL_GROUP;
   localparam int BURST_W = 8;
   // ********
   // control word fields
   // ********
   localparam int CW_CAL_RESET_BIT = 56;
   localparam int CW_CAL_HI = 55;
   localparam int CW_CAL_LO = 40;
   localparam int CW_MU_HI = 31;
   localparam int CW_MU_LO = 24;
   localparam int CW_CRC_HI = 23;
   localparam int CW_BODY_LO = 24;
   localparam int CW_BODY_W = 40;
   localparam logic [23:0] CRC24_POLY = 24'h32_8B63;
   localparam logic [23:0] CRC24_INIT = 24'hFF_FFFF;
   // ********
   // register map (byte offsets)
   // ********
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_STATUS = 6'h04;
   localparam logic [5:0] OFS_LANE_HEALTH = 6'h08;
   localparam logic [5:0] OFS_INTF_HEALTH = 6'h0C;
   localparam logic [5:0] OFS_CHECK_OK = 6'h10;
   localparam logic [5:0] OFS_CHECK_FAIL = 6'h14;
   localparam logic [5:0] OFS_MULTI_USE = 6'h18;
   localparam logic [5:0] OFS_CAL_BASE = 6'h20;
   localparam int CTRL_MIN_LO = 0;
   localparam int CTRL_MAX_LO = 8;
   localparam int ST_TX_SHORT = 0;
   localparam int ST_RX_LONG = 1;
   localparam int ST_CTRL_FAIL = 2;
   localparam int ST_ALIGNED = 8;
   localparam int ST_REALIGN = 9;
   localparam logic [BURST_W-1:0] MIN_BURST_RST = 8'h08;
   localparam logic [BURST_W-1:0] MAX_BURST_RST = 8'h20;
   // ********
   // carriers
   // ********
   typedef struct packed {
      logic txShort;
      logic rxLong;
      logic ctrlFail;
   } sticky_s;
   typedef struct packed {
      logic [LANES-1:0] laneHealth;
      logic [LANES-1:0] intfHealth;
      logic [LANES-1:0] checkOk;
      logic [LANES-1:0] failPulse;
   } diag_s;
   // ********
   // helpers
   // ********
   function automatic logic [23:0] crc24(input logic [CW_BODY_W-1:0] body);
      logic [23:0] c;
      c = CRC24_INIT;
      for (int i = CW_BODY_W - 1; i >= 0; i--) begin
         c = (c[23] ^ body[i]) ? ((c << 1) ^ CRC24_POLY) : (c << 1);
      end
      return c;
   endfunction : crc24
   function automatic logic [CAL_GROUP-1:0] rev16(input logic [CAL_GROUP-1:0] v);
      logic [CAL_GROUP-1:0] r;
      r = '0;
      for (int i = 0; i < CAL_GROUP; i++) begin
         r[i] = v[CAL_GROUP-1-i];
      end
      return r;
   endfunction : rev16
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask
endpackage : lane_link_pkg

// [verilog/sync_three.sv]
// three-stage synchroniser, output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module sync_three
   import lane_link_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // asynchronous level in, synchronised level out
   input wire logic asyncIn,
   output logic syncOut
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic out_reg;
   logic out_next;

   always_comb begin
      stage_next = {stage_reg[1:0], asyncIn};
      out_next = (stage_reg[2] == stage_reg[1]) ? stage_reg[1] : out_reg; // R21
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stage_reg <= '0;
         out_reg <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         out_reg <= out_next;
      end
   end

   assign syncOut = out_reg;

   a_sync_agree: assert property (@(posedge core_clk) disable iff (rst) // R21
      (stage_reg[2] == stage_reg[1]) |=> (syncOut == $past(stage_reg[1])))
      else $error("synchroniser output did not follow agreeing stages");
endmodule : sync_three
`default_nettype wire

// [verilog/burst_checker.sv]
// counts data words between control words and flags short or long bursts
`timescale 1ns/100ps
`default_nettype none
module burst_checker
   import lane_link_pkg::*;
#(
   parameter int W = BURST_W
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // word stream
   input wire logic wordValid,
   input wire logic wordIsCtrl,
   input wire logic wordEop,
   // limits
   input wire logic [W-1:0] minBurst,
   input wire logic [W-1:0] maxBurst,
   // one-cycle events
   output logic shortPulse,
   output logic longPulse
);
   logic [W:0] count_reg;
   logic [W:0] count_next;
   logic short_reg;
   logic short_next;
   logic long_reg;
   logic long_next;

   always_comb begin
      count_next = count_reg;
      short_next = 1'b0;
      long_next = 1'b0;
      if (wordValid) begin
         if (wordIsCtrl) begin
            // a closing word with end of packet never counts as short
            short_next = (count_reg != '0) && (count_reg < {1'b0, minBurst}) && !wordEop; // R1 R2
            count_next = '0;
         end else begin
            // saturate so a very long burst cannot wrap and flag twice
            if (count_reg != {(W+1){1'b1}}) begin
               count_next = count_reg + 1'b1;
            end
            long_next = (count_reg == {1'b0, maxBurst}); // R6
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= '0;
         short_reg <= 1'b0;
         long_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         short_reg <= short_next;
         long_reg <= long_next;
      end
   end

   assign shortPulse = short_reg;
   assign longPulse = long_reg;

   a_short_no_eop: assert property (@(posedge core_clk) disable iff (rst) // R2
      (wordValid && wordIsCtrl && wordEop) |=> !shortPulse)
      else $error("short burst flagged on an end of packet word");
endmodule : burst_checker
`default_nettype wire

// [verilog/lane_link_status.sv]
// lane link status and flow control block with an Avalon-MM register slave
// Rules of the document
// R1 - flag transmit bursts shorter than minimum
// R2 - no short flag when closing word has EOP
// R3 - user resets transmit side after short flag
// R4 - realign request resets and realigns receive lanes
// R5 - realign request is a pulse, normally low
// R6 - flag receive bursts longer than maximum
// R7 - per lane, show diagnostic bit 33
// R8 - per lane, show diagnostic bit 32
// R9 - health bits meaningful only when check ok
// R10 - per lane check ok follows latest word
// R11 - one-cycle check fail pulse per bad word
// R12 - calendar bits from control bits 55..40
// R13 - keep at most 256 calendar entries
// R14 - unrefreshed calendar bits keep old values
// R15 - first received entry lands in bit 0
// R16 - check error or alignment loss clears calendar
// R17 - show multi-use field of latest control word
// R18 - multi-use field on the core clock
// R19 - flag control word check code mismatch
// R20 - aligned only when every lane aligned
// R21 - synchronise the asynchronous realign request
`timescale 1ns/100ps
`default_nettype none
module lane_link_status
   import lane_link_pkg::*;
#(
   parameter int NLANES = LANES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [5:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   // transmit word stream
   input wire logic txWordValid,
   input wire logic txWordIsCtrl,
   input wire logic txWordEop,
   // receive word stream
   input wire logic rxWordValid,
   input wire logic rxWordIsCtrl,
   input wire logic rxWordEop,
   input wire logic [63:0] rxCtrlWord,
   // realign and lane alignment
   input wire logic rxRealignAsync,
   input wire logic [NLANES-1:0] rxLaneAlignedIn,
   // received diagnostic words, one strobe per lane
   input wire logic [NLANES-1:0] rxDiagValid,
   input wire logic [NLANES-1:0] rxDiagLaneBit,
   input wire logic [NLANES-1:0] rxDiagIntfBit,
   input wire logic [NLANES-1:0] rxDiagCrcOk,
   // status outputs
   output logic txShortBurstFlag,
   output logic rxLongBurstFlag,
   output logic rxLaneReset,
   output logic rxAligned,
   output logic rxCtrlWordCheckFail,
   output logic [NLANES-1:0] rxLaneHealthBits,
   output logic [NLANES-1:0] rxInterfaceHealthBits,
   output logic [NLANES-1:0] rxDiagCheckOk,
   output logic [NLANES-1:0] rxDiagCheckFailPulse,
   output logic [CAL_ENTRIES-1:0] rxCalendarXonBits,
   output logic [7:0] rxMultiUseField
);
   // ****************************************
   // state
   // ****************************************
   logic [BURST_W-1:0] minBurst_reg, minBurst_next;
   logic [BURST_W-1:0] maxBurst_reg, maxBurst_next;
   sticky_s sticky_reg, sticky_next;
   logic [NLANES-1:0] failSticky_reg, failSticky_next;
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   diag_s diag_reg, diag_next;
   logic [CAL_ENTRIES-1:0] cal_reg, cal_next;
   logic [4:0] calPtr_reg, calPtr_next;
   logic [7:0] mu_reg, mu_next;
   logic ctrlFail_reg, ctrlFail_next;
   logic aligned_reg, aligned_next;
   logic laneReset_reg, laneReset_next;

   logic realignSync;
   logic txShortPulse;
   logic rxLongPulse;
   logic ctrlSeen;
   logic ctrlBad;
   logic alignLoss;
   logic busDone;
   logic [31:0] wmask;

   // ****************************************
   // submodules
   // ****************************************
   sync_three realignSyncer (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(rxRealignAsync),
      .syncOut(realignSync)
   );

   burst_checker #(.W(BURST_W)) txBurst (
      .core_clk(core_clk),
      .rst(rst),
      .wordValid(txWordValid),
      .wordIsCtrl(txWordIsCtrl),
      .wordEop(txWordEop),
      .minBurst(minBurst_reg),
      .maxBurst(maxBurst_reg),
      .shortPulse(txShortPulse),
      .longPulse()
   );

   // receive checker runs in lane reset too; the stream is idle then anyway
   burst_checker #(.W(BURST_W)) rxBurst (
      .core_clk(core_clk),
      .rst(rst),
      .wordValid(rxWordValid),
      .wordIsCtrl(rxWordIsCtrl),
      .wordEop(rxWordEop),
      .minBurst(minBurst_reg),
      .maxBurst(maxBurst_reg),
      .shortPulse(),
      .longPulse(rxLongPulse)
   );

   // ****************************************
   // receive status
   // ****************************************
   assign ctrlSeen = rxWordValid && rxWordIsCtrl && !laneReset_reg;
   assign ctrlBad = ctrlSeen && (rxCtrlWord[CW_CRC_HI:0] != crc24(rxCtrlWord[CW_BODY_LO +: CW_BODY_W])); // R19
   assign alignLoss = aligned_reg && !aligned_next;

   always_comb begin
      laneReset_next = realignSync; // R4
      aligned_next = (&rxLaneAlignedIn) && !realignSync; // R20 R4
      ctrlFail_next = ctrlBad; // R19
      diag_next = diag_reg;
      diag_next.failPulse = '0;
      cal_next = cal_reg;
      calPtr_next = calPtr_reg;
      mu_next = mu_reg;
      if (realignSync) begin
         // lane logic held in reset: nothing received is trusted
         diag_next.checkOk = '0;
         calPtr_next = '0;
      end else begin
         diag_next.laneHealth = (diag_reg.laneHealth & ~rxDiagValid) | (rxDiagLaneBit & rxDiagValid); // R7
         diag_next.intfHealth = (diag_reg.intfHealth & ~rxDiagValid) | (rxDiagIntfBit & rxDiagValid); // R8
         diag_next.checkOk = (diag_reg.checkOk & ~rxDiagValid) | (rxDiagCrcOk & rxDiagValid); // R10
         diag_next.failPulse = rxDiagValid & ~rxDiagCrcOk; // R11
      end
      if (ctrlSeen) begin
         mu_next = rxCtrlWord[CW_MU_HI:CW_MU_LO]; // R17 R18
      end
      if (ctrlBad || alignLoss) begin
         cal_next = '0; // R16
         calPtr_next = '0;
      end else if (ctrlSeen) begin
         // a calendar start marker restarts at the first group
         if (rxCtrlWord[CW_CAL_RESET_BIT]) begin
            cal_next[0 +: CAL_GROUP] = rev16(rxCtrlWord[CW_CAL_HI:CW_CAL_LO]); // R12 R15
            calPtr_next = 5'd1;
         end else if (calPtr_reg < 5'(CAL_GROUPS)) begin // R13
            cal_next[calPtr_reg[3:0]*CAL_GROUP +: CAL_GROUP] = rev16(rxCtrlWord[CW_CAL_HI:CW_CAL_LO]); // R12 R14
            calPtr_next = calPtr_reg + 5'd1;
         end
      end
   end

   // ****************************************
   // register slave
   // ****************************************
   // one wait state: request seen with wait high, completed at the next edge
   assign busDone = (avsRead || avsWrite) && !wait_reg;
   assign wmask = lane_mask(avsByteEnable);

   always_comb begin
      wait_next = !((avsRead || avsWrite) && wait_reg);
      rdata_next = rdata_reg;
      minBurst_next = minBurst_reg;
      maxBurst_next = maxBurst_reg;
      sticky_next = sticky_reg;
      failSticky_next = failSticky_reg;
      if (avsWrite && busDone) begin
         case (avsAddress)
            OFS_CTRL: begin
               if (avsByteEnable[0]) begin
                  minBurst_next = avsWriteData[CTRL_MIN_LO +: BURST_W];
               end
               if (avsByteEnable[1]) begin
                  maxBurst_next = avsWriteData[CTRL_MAX_LO +: BURST_W];
               end
            end
            OFS_STATUS: begin
               sticky_next.txShort = sticky_reg.txShort & ~(avsWriteData[ST_TX_SHORT] & wmask[ST_TX_SHORT]);
               sticky_next.rxLong = sticky_reg.rxLong & ~(avsWriteData[ST_RX_LONG] & wmask[ST_RX_LONG]);
               sticky_next.ctrlFail = sticky_reg.ctrlFail & ~(avsWriteData[ST_CTRL_FAIL] & wmask[ST_CTRL_FAIL]);
            end
            OFS_CHECK_FAIL: begin
               failSticky_next = failSticky_reg & ~(avsWriteData[NLANES-1:0] & wmask[NLANES-1:0]);
            end
            default: begin
            end
         endcase
      end
      // hardware events win over a clear in the same cycle
      sticky_next.txShort = sticky_next.txShort | txShortPulse; // R1
      sticky_next.rxLong = sticky_next.rxLong | rxLongPulse; // R6
      sticky_next.ctrlFail = sticky_next.ctrlFail | ctrlFail_reg;
      failSticky_next = failSticky_next | diag_reg.failPulse;
      if (avsRead && wait_reg) begin
         rdata_next = '0;
         if (avsAddress >= OFS_CAL_BASE) begin
            rdata_next = cal_reg[avsAddress[4:2]*32 +: 32];
         end else begin
            case (avsAddress)
               OFS_CTRL: begin
                  rdata_next[CTRL_MIN_LO +: BURST_W] = minBurst_reg;
                  rdata_next[CTRL_MAX_LO +: BURST_W] = maxBurst_reg;
               end
               OFS_STATUS: begin
                  rdata_next[ST_TX_SHORT] = sticky_reg.txShort;
                  rdata_next[ST_RX_LONG] = sticky_reg.rxLong;
                  rdata_next[ST_CTRL_FAIL] = sticky_reg.ctrlFail;
                  rdata_next[ST_ALIGNED] = aligned_reg;
                  rdata_next[ST_REALIGN] = laneReset_reg;
               end
               OFS_LANE_HEALTH: rdata_next[NLANES-1:0] = diag_reg.laneHealth;
               OFS_INTF_HEALTH: rdata_next[NLANES-1:0] = diag_reg.intfHealth;
               OFS_CHECK_OK: rdata_next[NLANES-1:0] = diag_reg.checkOk;
               OFS_CHECK_FAIL: rdata_next[NLANES-1:0] = failSticky_reg;
               OFS_MULTI_USE: rdata_next[7:0] = mu_reg;
               default: rdata_next = '0;
            endcase
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         minBurst_reg <= MIN_BURST_RST;
         maxBurst_reg <= MAX_BURST_RST;
         sticky_reg <= '0;
         failSticky_reg <= '0;
         wait_reg <= 1'b1;
         rdata_reg <= '0;
         diag_reg <= '0;
         cal_reg <= '0;
         calPtr_reg <= '0;
         mu_reg <= '0;
         ctrlFail_reg <= 1'b0;
         aligned_reg <= 1'b0;
         laneReset_reg <= 1'b0;
      end else begin
         minBurst_reg <= minBurst_next;
         maxBurst_reg <= maxBurst_next;
         sticky_reg <= sticky_next;
         failSticky_reg <= failSticky_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         diag_reg <= diag_next;
         cal_reg <= cal_next;
         calPtr_reg <= calPtr_next;
         mu_reg <= mu_next;
         ctrlFail_reg <= ctrlFail_next;
         aligned_reg <= aligned_next;
         laneReset_reg <= laneReset_next;
      end
   end

   assign avsReadData = rdata_reg;
   assign avsWaitRequest = wait_reg;
   assign txShortBurstFlag = sticky_reg.txShort;
   assign rxLongBurstFlag = sticky_reg.rxLong;
   assign rxLaneReset = laneReset_reg;
   assign rxAligned = aligned_reg;
   assign rxCtrlWordCheckFail = ctrlFail_reg;
   assign rxLaneHealthBits = diag_reg.laneHealth;
   assign rxInterfaceHealthBits = diag_reg.intfHealth;
   assign rxDiagCheckOk = diag_reg.checkOk;
   assign rxDiagCheckFailPulse = diag_reg.failPulse;
   assign rxCalendarXonBits = cal_reg;
   assign rxMultiUseField = mu_reg;

   // ****************************************
   // assertions
   // ****************************************
   a_short_flag_set: assert property (@(posedge core_clk) disable iff (rst) // R1
      txShortPulse |=> txShortBurstFlag)
      else $error("short burst event did not set flag");
   a_long_flag_set: assert property (@(posedge core_clk) disable iff (rst) // R6
      rxLongPulse |=> rxLongBurstFlag)
      else $error("long burst event did not set flag");
   a_realign_blocks: assert property (@(posedge core_clk) disable iff (rst) // R4
      rxLaneReset |-> !rxAligned)
      else $error("aligned shown during lane reset");
   a_aligned_all: assert property (@(posedge core_clk) disable iff (rst) // R20
      rxAligned |-> $past(&rxLaneAlignedIn))
      else $error("aligned without every lane aligned");
   a_health_follow: assert property (@(posedge core_clk) disable iff (rst) // R7
      (rxDiagValid[0] && !realignSync) |=> (rxLaneHealthBits[0] == $past(rxDiagLaneBit[0])))
      else $error("lane health bit not updated");
   a_check_ok_follow: assert property (@(posedge core_clk) disable iff (rst) // R10
      (rxDiagValid[1] && !realignSync) |=> (rxDiagCheckOk[1] == $past(rxDiagCrcOk[1])))
      else $error("check ok bit not updated");
   a_fail_pulse_excl: assert property (@(posedge core_clk) disable iff (rst) // R11
      ((rxDiagCheckFailPulse & rxDiagCheckOk) == '0))
      else $error("fail pulse with check ok");
   a_cal_clear: assert property (@(posedge core_clk) disable iff (rst) // R16
      ctrlBad |=> (rxCalendarXonBits == '0) && rxCtrlWordCheckFail)
      else $error("calendar not cleared on check error");
   a_cal_first: assert property (@(posedge core_clk) disable iff (rst) // R15
      (ctrlSeen && !ctrlBad && !alignLoss && rxCtrlWord[CW_CAL_RESET_BIT])
      |=> (rxCalendarXonBits[0] == $past(rxCtrlWord[CW_CAL_HI])))
      else $error("first calendar entry not in bit 0");
   a_mu_capture: assert property (@(posedge core_clk) disable iff (rst) // R17
      ctrlSeen |=> (rxMultiUseField == $past(rxCtrlWord[CW_MU_HI:CW_MU_LO])))
      else $error("multi-use field not captured");
   a_cal_bound: assert property (@(posedge core_clk) disable iff (rst) // R13
      (calPtr_reg <= 5'(CAL_GROUPS)))
      else $error("calendar pointer past last group");
endmodule : lane_link_status
`default_nettype wire

// [tb/link_partner.sv]
// remote link partner model: receive word stream and diagnostic strobes
`timescale 1ns/100ps
`default_nettype none
module link_partner
   import lane_link_pkg::*;
(
   // clock
   input wire logic core_clk,
   // word stream towards the block
   output logic rxWordValid,
   output logic rxWordIsCtrl,
   output logic rxWordEop,
   output logic [63:0] rxCtrlWord,
   // diagnostic strobes
   output logic [LANES-1:0] rxDiagValid,
   output logic [LANES-1:0] rxDiagLaneBit,
   output logic [LANES-1:0] rxDiagIntfBit,
   output logic [LANES-1:0] rxDiagCrcOk
);
   // ********
   // driving tasks
   // ********
   initial begin
      {rxWordValid, rxWordIsCtrl, rxWordEop, rxCtrlWord, rxDiagValid, rxDiagLaneBit, rxDiagIntfBit, rxDiagCrcOk} = '0;
   end
   task word(input logic c, input logic e, input logic [63:0] w);
      @(posedge core_clk);
      rxWordValid <= 1'b1;
      rxWordIsCtrl <= c;
      rxWordEop <= e;
      rxCtrlWord <= w;
   endtask : word
   // released control word and lane and interface bit lines flip so a stale value never looks held
   task idle();
      @(posedge core_clk);
      rxWordValid <= 1'b0;
      rxDiagValid <= '0;
      rxCtrlWord <= ~rxCtrlWord;
      rxDiagLaneBit <= ~rxDiagLaneBit;
      rxDiagIntfBit <= ~rxDiagIntfBit;
   endtask : idle
   task ctrl(input logic [15:0] e, input logic [7:0] mu, input logic st, input logic bad);
      logic [63:0] w;
      logic [23:0] c;
      w = '0;
      w[CW_CAL_RESET_BIT] = st;
      for (int j = 0; j < 16; j++) w[55-j] = e[j];
      w[31:24] = mu;
      c = CRC24_INIT;
      for (int i = 63; i >= 24; i--) c = {c[22:0], 1'b0} ^ ((c[23] ^ w[i]) ? CRC24_POLY : '0);
      w[23:0] = bad ? ~c : c;
      word(1'b1, 1'b0, w);
   endtask : ctrl
   task diag(input logic [11:0] v, input logic [11:0] l, input logic [11:0] i, input logic [11:0] o);
      @(posedge core_clk);
      rxDiagValid <= v;
      rxDiagLaneBit <= l;
      rxDiagIntfBit <= i;
      rxDiagCrcOk <= o;
   endtask : diag
endmodule : link_partner
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the lane link status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin checks++; if ((sn) !== (ex)) begin n_errors++; $display("[FAIL] %s exp %0h seen %0h", nm, ex, sn); end end
module tb_top
   import lane_link_pkg::*;
;
   logic core_clk, rst, avsRead, avsWrite, avsWaitRequest, txWordValid, txWordIsCtrl, txWordEop;
   logic rxWordValid, rxWordIsCtrl, rxWordEop, rxRealignAsync, txShortBurstFlag, rxLongBurstFlag;
   logic rxLaneReset, rxAligned, rxCtrlWordCheckFail;
   logic [5:0] avsAddress;
   logic [31:0] avsWriteData, avsReadData, q;
   logic [63:0] rxCtrlWord;
   logic [LANES-1:0] rxLaneAlignedIn, rxDiagValid, rxDiagLaneBit, rxDiagIntfBit, rxDiagCrcOk, seen;
   logic [LANES-1:0] rxLaneHealthBits, rxInterfaceHealthBits, rxDiagCheckOk, rxDiagCheckFailPulse;
   logic [CAL_ENTRIES-1:0] rxCalendarXonBits;
   logic [7:0] rxMultiUseField;
   logic [3:0] hits;
   int n_errors, checks, k;
   lane_link_status DUT (.core_clk, .rst, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable(4'hF),
      .avsReadData, .avsWaitRequest, .txWordValid, .txWordIsCtrl, .txWordEop, .rxWordValid, .rxWordIsCtrl,
      .rxWordEop, .rxCtrlWord, .rxRealignAsync, .rxLaneAlignedIn, .rxDiagValid, .rxDiagLaneBit, .rxDiagIntfBit,
      .rxDiagCrcOk, .txShortBurstFlag, .rxLongBurstFlag, .rxLaneReset, .rxAligned, .rxCtrlWordCheckFail,
      .rxLaneHealthBits, .rxInterfaceHealthBits, .rxDiagCheckOk, .rxDiagCheckFailPulse, .rxCalendarXonBits,
      .rxMultiUseField);
   link_partner p (.core_clk, .rxWordValid, .rxWordIsCtrl, .rxWordEop, .rxCtrlWord, .rxDiagValid,
      .rxDiagLaneBit, .rxDiagIntfBit, .rxDiagCrcOk);
   // ********
   // shared tasks
   // ********
   task stop_test();
      if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avsRead <= ~w;
      avsWrite <= w;
      avsAddress <= a;
      avsWriteData <= d;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avsWaitRequest !== 1'b0 && k < 20);
      if (k >= 20) begin
         n_errors++;
         stop_test();
      end
      q = avsReadData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask : bus
   task tx(input logic c, input logic e);
      @(posedge core_clk);
      txWordValid <= 1'b1;
      txWordIsCtrl <= c;
      txWordEop <= e;
   endtask : tx
   task tx_burst(input int n, input logic e);
      tx(1'b1, 1'b0);
      repeat (n) tx(1'b0, 1'b0);
      tx(1'b1, e);
      @(posedge core_clk);
      txWordValid <= 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : tx_burst
   task settle();
      p.idle();
      repeat (3) @(negedge core_clk);
   endtask : settle
   task wait_reset(input logic v);
      for (k = 0; k < 12 && rxLaneReset !== v; k++) @(negedge core_clk);
      if (k >= 12) begin
         n_errors++;
         stop_test();
      end
   endtask : wait_reset
   // ********
   // scenarios
   // ********
   task regs_test();
      bus(1'b0, OFS_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h0000_2008, q)
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK("status reset", 32'h0000_0100, q)
      bus(1'b1, 6'h1C, 32'hFFFF_FFFF);
      bus(1'b0, 6'h1C, 32'h0);
      `CHK("unmapped", 32'h0000_0000, q)
   endtask : regs_test
   task short_test();
      tx_burst(8, 1'b0);
      `CHK("short at min", 1'b0, txShortBurstFlag)
      tx_burst(7, 1'b0);
      `CHK("short below min", 1'b1, txShortBurstFlag)
      bus(1'b1, OFS_STATUS, 32'h0000_0001);
      @(negedge core_clk);
      `CHK("short cleared", 1'b0, txShortBurstFlag)
      tx_burst(3, 1'b1);
      `CHK("short with eop", 1'b0, txShortBurstFlag)
   endtask : short_test
   task diag_test();
      p.diag(12'hFFF, 12'hA5A, 12'h3C3, 12'hF0F);
      p.idle();
      seen = '0;
      hits = '0;
      repeat (4) begin
         @(negedge core_clk);
         seen |= rxDiagCheckFailPulse;
         hits += |rxDiagCheckFailPulse;
      end
      `CHK("fail lanes", 12'h0F0, seen)
      `CHK("fail cycles", 4'h1, hits)
      `CHK("lane health", 12'hA5A, rxLaneHealthBits)
      `CHK("intf health", 12'h3C3, rxInterfaceHealthBits)
      `CHK("check ok", 12'hF0F, rxDiagCheckOk)
      p.diag(12'h010, 12'h000, 12'h010, 12'h010);
      settle();
      `CHK("check ok lane", 12'hF1F, rxDiagCheckOk)
      `CHK("lane health lane", 12'hA4A, rxLaneHealthBits)
      `CHK("intf health lane", 12'h3D3, rxInterfaceHealthBits)
   endtask : diag_test
   task cal_test();
      for (int g = 0; g < 17; g++) p.ctrl(16'h1230 + g[15:0], g[7:0], g == 0, 1'b0);
      settle();
      for (int g = 0; g < 16; g++) `CHK("cal group", 16'h1230 + g[15:0], rxCalendarXonBits[16*g+:16])
      `CHK("multi-use", 8'h10, rxMultiUseField)
      p.ctrl(16'hBEEF, 8'h5A, 1'b1, 1'b0);
      settle();
      `CHK("cal refresh", 16'hBEEF, rxCalendarXonBits[15:0])
      `CHK("cal kept", 16'h1231, rxCalendarXonBits[31:16])
      p.ctrl(16'h0000, 8'hC3, 1'b0, 1'b1);
      p.idle();
      hits = '0;
      repeat (4) begin
         @(negedge core_clk);
         hits += rxCtrlWordCheckFail;
      end
      `CHK("ctrl fail cycles", 4'h1, hits)
      `CHK("cal cleared", 256'h0, rxCalendarXonBits)
      `CHK("multi-use bad", 8'hC3, rxMultiUseField)
   endtask : cal_test
   task long_test();
      for (int n = 32; n < 34; n++) begin
         p.ctrl(16'h0, 8'h0, 1'b0, 1'b0);
         repeat (n) p.word(1'b0, 1'b0, 64'h0);
         p.ctrl(16'h0, 8'h0, 1'b0, 1'b0);
         settle();
         `CHK("long burst", n == 33, rxLongBurstFlag)
      end
   endtask : long_test
   task align_test();
      p.ctrl(16'hBEEF, 8'h0, 1'b1, 1'b0);
      p.idle();
      rxLaneAlignedIn <= 12'hFDF;
      repeat (3) @(negedge core_clk);
      `CHK("one lane down", 1'b0, rxAligned)
      `CHK("cal on loss", 256'h0, rxCalendarXonBits)
      @(posedge core_clk);
      rxLaneAlignedIn <= 12'hFFF;
      repeat (3) @(negedge core_clk);
      `CHK("all lanes up", 1'b1, rxAligned)
   endtask : align_test
   task realign_test();
      @(posedge core_clk);
      rxRealignAsync <= 1'b1;
      repeat (3) @(posedge core_clk);
      rxRealignAsync <= 1'b0;
      wait_reset(1'b1);
      `CHK("lane reset", 1'b1, rxLaneReset)
      `CHK("aligned in reset", 1'b0, rxAligned)
      wait_reset(1'b0);
      repeat (3) @(negedge core_clk);
      `CHK("realigned", 1'b1, rxAligned)
   endtask : realign_test
   // ********
   // clock, sequence and watchdog
   // ********
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      {avsRead, avsWrite, avsAddress, avsWriteData} = '0;
      rst = 1'b1;
      {txWordValid, txWordIsCtrl, txWordEop, rxRealignAsync} = '0;
      rxLaneAlignedIn = 12'hFFF;
      n_errors = 0;
      checks = 0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      regs_test();
      short_test();
      diag_test();
      cal_test();
      long_test();
      align_test();
      realign_test();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
